// [verilog/uebc_pkg.sv]
// package for the endpoint command block: command codes, status bit positions
// assumes a single clock domain; used by uebc_ep_state and uebc_top
package uebc_pkg;
	localparam int NUM_EP = 16;
	localparam int EP_W = 4;
	// ===========================================
	// command code high nibbles, the set-up ack code and control endpoint numbers
	localparam logic [3:0] OP_STALL = 4'h4;
	localparam logic [3:0] OP_DSTAT = 4'h5;
	localparam logic [3:0] OP_VALID = 4'h6;
	localparam logic [3:0] OP_CLEAR = 4'h7;
	localparam logic [3:0] OP_UNSTALL = 4'h8;
	localparam logic [3:0] OP_COPY = 4'hd;
	localparam logic [7:0] CMD_SETUP_ACK = 8'hf4;
	localparam logic [3:0] EP_CTRL_OUT = 4'h0;
	localparam logic [3:0] EP_CTRL_IN = 4'h1;
	// ===========================================
	// status byte bit positions
	localparam int BIT_HALT = 7;
	localparam int BIT_FULL1 = 6;
	localparam int BIT_FULL0 = 5;
	localparam int BIT_TOGGLE = 4;
	localparam int BIT_CLOB = 3;
	localparam int BIT_SETUP = 2;
	localparam int BIT_BUFSEL = 1;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// ===========================================
	// endpoint-level command after decode
	typedef enum logic [2:0] {
		UEBC_EC_NONE, UEBC_EC_STALL, UEBC_EC_UNSTALL, UEBC_EC_VALID, UEBC_EC_CLEAR
	} uebc_ep_cmd_t;
endpackage

// [verilog/uebc_ep_state.sv]
// one endpoint's status state: halt, buffer fill, toggle, buffer select
// assumes commands and usb events arrive as one-cycle pulses on i_ref_clk
`timescale 1ns/100ps
module uebc_ep_state import uebc_pkg::*; #(
	parameter bit IS_IN = 1'b0,
	parameter bit DOUBLE_BUF = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire uebc_ep_cmd_t i_cmd,
	input wire logic i_setup_tok,
	input wire logic i_setup_done,
	input wire logic i_setup_ack,
	input wire logic i_copy_read,
	input wire logic i_out_pkt,
	input wire logic i_in_tok,
	output logic o_halted,
	output logic o_nak,
	output logic o_send,
	output logic [7:0] o_status
);
	logic halted, full0, full1, toggle, clobbered, setup_present, bufsel;
	logic setup_pending, fill_sel;
	logic all_full, unhalt, setup_lock;

	assign all_full = full0 & (!DOUBLE_BUF | full1);
	assign unhalt = (halted & i_cmd == UEBC_EC_UNSTALL) | i_setup_tok;
	assign setup_lock = setup_present;
	assign o_halted = halted;
	assign o_nak = !IS_IN & !halted & all_full;
	assign o_send = IS_IN & !halted & i_in_tok & (fill_sel ? full1 : full0);

	// ===========================================
	// halt flag
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			halted <= 1'b0;
		end else if (i_ce) begin
			if (i_setup_tok) begin
				halted <= 1'b0;
			end else if (i_cmd == UEBC_EC_STALL) begin
				halted <= 1'b1;
			end else if (i_cmd == UEBC_EC_UNSTALL) begin
				halted <= 1'b0;
			end
		end
	end

	// ===========================================
	// buffers, toggle and selection; unhalt re-initialises all of it
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			full0 <= 1'b0;
			full1 <= 1'b0;
			toggle <= 1'b0;
			bufsel <= 1'b0;
			fill_sel <= 1'b0;
		end else if (i_ce) begin
			if (unhalt) begin
				full0 <= 1'b0;
				full1 <= 1'b0;
				toggle <= 1'b0;
				bufsel <= 1'b0;
				fill_sel <= 1'b0;
			end else begin
				if (IS_IN && i_cmd == UEBC_EC_VALID && !(setup_lock)) begin
					if (bufsel) full1 <= 1'b1; else full0 <= 1'b1;
					if (DOUBLE_BUF) bufsel <= !bufsel;
				end
				if (!IS_IN && i_cmd == UEBC_EC_CLEAR && !(setup_lock)) begin
					if (bufsel) full1 <= 1'b0; else full0 <= 1'b0;
					if (DOUBLE_BUF) bufsel <= !bufsel;
				end
				if (!IS_IN && i_out_pkt && !halted && !all_full) begin
					// a packet arriving while full is refused, so no flag or toggle change
					if (fill_sel) full1 <= 1'b1; else full0 <= 1'b1;
					toggle <= !toggle;
					if (DOUBLE_BUF) fill_sel <= !fill_sel;
				end
				if (o_send) begin
					if (fill_sel) full1 <= 1'b0; else full0 <= 1'b0;
					toggle <= !toggle;
					if (DOUBLE_BUF) fill_sel <= !fill_sel;
				end
			end
		end
	end

	// ===========================================
	// set-up presence and setup_clobbered detection
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			setup_present <= 1'b0;
			clobbered <= 1'b0;
			setup_pending <= 1'b0;
		end else if (i_ce) begin
			if (i_setup_tok) begin
				setup_present <= 1'b1;
				setup_pending <= 1'b1;
				if (setup_present) clobbered <= 1'b1;
			end else begin
				if (i_setup_ack | i_cmd == UEBC_EC_STALL) setup_present <= 1'b0;
				if (i_setup_done) setup_pending <= 1'b0;
				// read clears only once the new set-up data is fully written
				if (i_copy_read && !setup_pending) clobbered <= 1'b0;
			end
		end
	end

	always_comb begin
		o_status = STATUS_RESET;
		o_status[BIT_HALT] = halted;
		o_status[BIT_FULL1] = DOUBLE_BUF & full1;
		o_status[BIT_FULL0] = full0;
		o_status[BIT_TOGGLE] = toggle;
		o_status[BIT_CLOB] = clobbered;
		o_status[BIT_SETUP] = setup_present;
		o_status[BIT_BUFSEL] = bufsel;
	end

	a_setup_unhalt: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_setup_tok |=> !halted && !full0 && !toggle)
		else $error("set-up token did not re-initialise the endpoint");
	a_out_nak: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		!IS_IN && i_ce && i_out_pkt && o_nak && !i_setup_tok && i_cmd == UEBC_EC_NONE
		|=> $stable(full0) && $stable(toggle))
		else $error("refused packet changed endpoint state");
endmodule

// [verilog/uebc_top.sv]
// endpoint command logic: decodes byte commands from the local processor
// assumes command strobe and usb event pulses are synchronous to i_ref_clk
`timescale 1ns/100ps
// What this block does
// - codes 40h-4Fh stall the addressed endpoint, no data phase
// - codes 80h-8Fh unstall the addressed endpoint, no data phase
// - a set-up token unstalls a stalled control endpoint
// - leaving stall flushes buffer and resets toggle to DATA0
// - codes 61h-6Fh mark the IN buffer full for sending
// - a validated IN buffer goes out on the next IN token
// - validate flips processor buffer select when double buffered
// - codes 70h,72h-7Fh empty the OUT buffer, flip select if doubled
// - a complete OUT packet sets that endpoint's full flag
// - further OUT packets are NAKed while the buffer stays full
// - codes D0h-DFh return status copy, clearing only the overwritten set-up bit 3
// - status bit 7 halted, 6 second full, 5 first full, 0 reserved
// - status bit 4 toggle, bit 2 set-up present, bit 1 buffer select
// - bit 3 marks overwritten set-up, cleared by a status copy read once the new set-up data is written
// - code F4h acknowledges a set-up packet, no data phase
// - after set-up, control validate and clear are ignored until ack or a stall of that endpoint
// - codes 50h-5Fh read status and clear the endpoint event flag
module uebc_top import uebc_pkg::*; #(
	parameter logic [NUM_EP-1:0] DOUBLE_MASK = 16'h0000,
	parameter logic [NUM_EP-1:0] IN_MASK = 16'haaaa
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_cmd_stb,
	input wire logic [7:0] i_cmd_code,
	input wire logic i_setup_tok,
	input wire logic i_setup_done,
	input wire logic i_out_pkt,
	input wire logic i_in_tok,
	input wire logic [EP_W-1:0] i_usb_ep,
	input wire logic [NUM_EP-1:0] i_ep_event,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic [NUM_EP-1:0] o_event_flags,
	output logic [NUM_EP-1:0] o_halted,
	output logic [NUM_EP-1:0] o_nak,
	output logic [NUM_EP-1:0] o_send
);
	logic [3:0] op, sel;
	logic [7:0] status [NUM_EP];
	logic [NUM_EP-1:0] ev_clear;

	assign op = i_cmd_code[7:4];
	assign sel = i_cmd_code[3:0];

	// direction check used by validate and clear
	function automatic logic dir_ok(input logic [3:0] ep, input logic want_in);
		dir_ok = (IN_MASK[ep] == want_in);
	endfunction

	// both status reads share one answer path
	function automatic logic is_read(input logic [3:0] code_op);
		is_read = (code_op == OP_COPY) || (code_op == OP_DSTAT);
	endfunction

	// ===========================================
	// per-endpoint state
	for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
		uebc_ep_cmd_t ecmd;
		logic is_ctrl, hit;
		assign is_ctrl = (e == EP_CTRL_OUT) || (e == EP_CTRL_IN);
		assign hit = i_cmd_stb && sel == e;
		always_comb begin
			ecmd = UEBC_EC_NONE;
			if (hit) begin
				unique case (op)
					OP_STALL: ecmd = UEBC_EC_STALL;
					OP_UNSTALL: ecmd = UEBC_EC_UNSTALL;
					OP_VALID: if (dir_ok(sel, 1'b1)) ecmd = UEBC_EC_VALID;
					OP_CLEAR: if (dir_ok(sel, 1'b0)) ecmd = UEBC_EC_CLEAR;
					default: ecmd = UEBC_EC_NONE;
				endcase
			end
		end
		uebc_ep_state #(
			.IS_IN(IN_MASK[e]),
			.DOUBLE_BUF(DOUBLE_MASK[e])
		) u_ep (
			.i_ref_clk(i_ref_clk),
			.i_sys_rst(i_sys_rst),
			.i_ce(i_ce),
			.i_cmd(ecmd),
			.i_setup_tok(i_setup_tok && is_ctrl && i_usb_ep == EP_CTRL_OUT),
			.i_setup_done(i_setup_done && is_ctrl),
			.i_setup_ack(i_cmd_stb && i_cmd_code == CMD_SETUP_ACK && is_ctrl),
			.i_copy_read(hit && op == OP_COPY),
			.i_out_pkt(i_out_pkt && i_usb_ep == e),
			.i_in_tok(i_in_tok && i_usb_ep == e),
			.o_halted(o_halted[e]),
			.o_nak(o_nak[e]),
			.o_send(o_send[e]),
			.o_status(status[e])
		);
		assign ev_clear[e] = hit && op == OP_DSTAT;
	end

	// ===========================================
	// endpoint event flags, set wins over clear
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_event_flags <= '0;
		end else if (i_ce) begin
			o_event_flags <= (o_event_flags & ~ev_clear) | i_ep_event;
		end
	end

	// ===========================================
	// read data: both status reads return the same byte one cycle later
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= STATUS_RESET;
		end else if (i_ce) begin
			o_rd_valid <= i_cmd_stb && is_read(op);
			if (i_cmd_stb && is_read(op)) begin
				o_rd_data <= status[sel];
			end
		end
	end

	a_copy_no_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_cmd_stb && op == OP_COPY && o_event_flags[sel]
		|=> o_event_flags[$past(sel)])
		else $error("status copy cleared an event flag");
	a_read_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_cmd_stb && op == OP_COPY |=> o_rd_valid && o_rd_data[0] == 1'b0)
		else $error("status copy answer missing or reserved bit set");
	a_stall_sets: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_cmd_stb && op == OP_STALL && !i_setup_tok |=> o_halted[$past(sel)])
		else $error("stall command did not halt endpoint");
	a_unstall_clr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_cmd_stb && op == OP_UNSTALL |=> !o_halted[$past(sel)])
		else $error("unstall command left endpoint halted");
	a_dstat_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_cmd_stb && op == OP_DSTAT && !i_ep_event[sel]
		|=> !o_event_flags[$past(sel)])
		else $error("destructive read did not clear event flag");
	a_setup_release: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_ce && i_setup_tok && i_usb_ep == EP_CTRL_OUT |=> !o_halted[0] && !o_halted[1])
		else $error("set-up token left control endpoint halted");

	c_stall: cover property (@(posedge i_ref_clk) i_cmd_stb && op == OP_STALL);
	c_send: cover property (@(posedge i_ref_clk) |o_send);
	c_nak: cover property (@(posedge i_ref_clk) i_out_pkt && |o_nak);
	c_setup_ack: cover property (@(posedge i_ref_clk) i_cmd_stb && i_cmd_code == CMD_SETUP_ACK);
endmodule

// [test/uebc_host_model.sv]
// usb host stand-in: raises token and packet pulses toward the endpoint logic
// assumes the bench calls send(); pulses launch on the falling clock edge
`timescale 1ns/100ps
module uebc_host_model (
	input wire logic i_ref_clk,
	output logic o_setup_tok,
	output logic o_setup_done,
	output logic o_out_pkt,
	output logic o_in_tok,
	output logic [3:0] o_usb_ep
);
	initial begin
		{o_setup_tok, o_setup_done, o_out_pkt, o_in_tok} = 4'h0;
		o_usb_ep = 4'h0;
	end
	// kind: 0 set-up token, 1 set-up data written, 2 out packet, 3 in token
	task automatic send(input logic [1:0] kind, input logic [3:0] ep);
		@(negedge i_ref_clk);
		o_usb_ep = ep;
		o_setup_tok = (kind == 2'd0);
		o_setup_done = (kind == 2'd1);
		o_out_pkt = (kind == 2'd2);
		o_in_tok = (kind == 2'd3);
		@(negedge i_ref_clk);
		{o_setup_tok, o_setup_done, o_out_pkt, o_in_tok} = 4'h0;
		// index released: show its inverse so a stale value never looks live
		o_usb_ep = ~ep;
	endtask
endmodule

// [test/uebc_top_test.sv]
// self-checking bench for the endpoint command logic
// assumes uebc_pkg compiled first; indices 4 and 5 are built double buffered
`timescale 1ns/100ps
module uebc_top_test import uebc_pkg::*;;
	logic i_ref_clk, i_sys_rst, i_ce, i_cmd_stb, o_rd_valid;
	logic i_setup_tok, i_setup_done, i_out_pkt, i_in_tok;
	logic [7:0] i_cmd_code, o_rd_data, rd;
	logic [EP_W-1:0] i_usb_ep;
	logic [NUM_EP-1:0] i_ep_event, o_event_flags, o_halted, o_nak, o_send;
	int n_fail, tests_run, sends;
	uebc_top #(.DOUBLE_MASK(16'h0030), .IN_MASK(16'haaaa)) uebc_top_inst (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
		.i_cmd_stb(i_cmd_stb), .i_cmd_code(i_cmd_code), .i_setup_tok(i_setup_tok),
		.i_setup_done(i_setup_done), .i_out_pkt(i_out_pkt), .i_in_tok(i_in_tok),
		.i_usb_ep(i_usb_ep), .i_ep_event(i_ep_event), .o_rd_valid(o_rd_valid),
		.o_rd_data(o_rd_data), .o_event_flags(o_event_flags), .o_halted(o_halted),
		.o_nak(o_nak), .o_send(o_send));
	uebc_host_model uebc_host_model_inst (.i_ref_clk(i_ref_clk),
		.o_setup_tok(i_setup_tok), .o_setup_done(i_setup_done),
		.o_out_pkt(i_out_pkt), .o_in_tok(i_in_tok), .o_usb_ep(i_usb_ep));
	// ====================
	// clock and send counter
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		if (|o_send)
			sends <= sends + 1;
	end
	// ====================
	// tasks
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] code);
		@(negedge i_ref_clk);
		i_cmd_stb = 1'b1;
		i_cmd_code = code;
		@(negedge i_ref_clk);
		i_cmd_stb = 1'b0;
	endtask
	task automatic rds(input logic [3:0] op, input logic [3:0] ep, output logic [7:0] v);
		int k;
		cmd({op, ep});
		for (k = 0; k < 4 && o_rd_valid !== 1'b1; k++)
			@(negedge i_ref_clk);
		if (o_rd_valid !== 1'b1) begin
			n_fail++;
			$display("unexpected timeout: no read valid");
			summarize();
		end
		v = o_rd_data;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ====================
	// sequence
	initial begin
		int e;
		i_sys_rst = 1'b1;
		i_cmd_stb = 1'b0;
		i_cmd_code = 8'h00;
		i_ep_event = 16'h0000;
		i_ce = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		rds(OP_COPY, 4'h3, rd);
		chk("reset status", rd, STATUS_RESET);
		for (e = 0; e < NUM_EP; e++) begin
			cmd({OP_STALL, 4'(e)});
			chk("halted", 8'(o_halted[e]), 8'h01);
			rds(OP_COPY, 4'(e), rd);
			chk("stall status", rd, 8'h80);
			cmd({OP_UNSTALL, 4'(e)});
			chk("unhalted", 8'(o_halted[e]), 8'h00);
		end
		$display("test stall done");
		cmd(8'h63);
		cmd(8'h73);
		rds(OP_COPY, 4'h3, rd);
		chk("in full", rd, 8'h20);
		uebc_host_model_inst.send(2'd3, 4'h3);
		uebc_host_model_inst.send(2'd3, 4'h3);
		chk("sends", 8'(sends), 8'h01);
		rds(OP_COPY, 4'h3, rd);
		chk("in sent", rd, 8'h10);
		cmd(8'h63);
		cmd(8'h43);
		cmd(8'h83);
		rds(OP_COPY, 4'h3, rd);
		chk("in reinit", rd, 8'h00);
		uebc_host_model_inst.send(2'd2, 4'h2);
		chk("nak", 8'(o_nak[2]), 8'h01);
		uebc_host_model_inst.send(2'd2, 4'h2);
		cmd(8'h62);
		rds(OP_COPY, 4'h2, rd);
		chk("out full", rd, 8'h30);
		cmd(8'h72);
		rds(OP_COPY, 4'h2, rd);
		chk("out clear", rd, 8'h10);
		chk("nak off", 8'(o_nak[2]), 8'h00);
		cmd(8'h65);
		rds(OP_COPY, 4'h5, rd);
		chk("dbl in 1", rd & 8'h62, 8'h22);
		cmd(8'h65);
		rds(OP_COPY, 4'h5, rd);
		chk("dbl in 2", rd & 8'h62, 8'h60);
		cmd(8'h74);
		rds(OP_COPY, 4'h4, rd);
		chk("dbl out", rd & 8'h02, 8'h02);
		$display("test buffers done");
		cmd({OP_STALL, EP_CTRL_OUT});
		uebc_host_model_inst.send(2'd0, 4'h0);
		chk("setup unhalt", 8'(o_halted[0]), 8'h00);
		cmd({OP_STALL, EP_CTRL_OUT});
		chk("restall", 8'(o_halted[0]), 8'h01);
		// the control IN copy still holds the first set-up; end that handling too
		cmd(CMD_SETUP_ACK);
		cmd({OP_UNSTALL, EP_CTRL_OUT});
		uebc_host_model_inst.send(2'd0, 4'h0);
		cmd(8'h61);
		rds(OP_COPY, EP_CTRL_IN, rd);
		chk("setup block", rd, 8'h04);
		uebc_host_model_inst.send(2'd0, 4'h0);
		rds(OP_COPY, EP_CTRL_OUT, rd);
		chk("clobber", rd, 8'h0c);
		uebc_host_model_inst.send(2'd1, 4'h0);
		rds(OP_COPY, EP_CTRL_OUT, rd);
		rds(OP_COPY, EP_CTRL_IN, rd);
		chk("in clobber", rd, 8'h0c);
		rds(OP_COPY, EP_CTRL_OUT, rd);
		chk("clobber gone", rd, 8'h04);
		// ack only once the setup_clobbered flag reads clear
		if (rd[BIT_CLOB] === 1'b0)
			cmd(CMD_SETUP_ACK);
		cmd(8'h61);
		rds(OP_COPY, EP_CTRL_IN, rd);
		chk("after ack", rd, 8'h20);
		$display("test setup done");
		@(negedge i_ref_clk);
		i_ep_event = 16'h0020;
		@(negedge i_ref_clk);
		i_ep_event = 16'h0000;
		rds(OP_COPY, 4'h5, rd);
		chk("flag kept", 8'(o_event_flags[5]), 8'h01);
		rds(OP_DSTAT, 4'h5, rd);
		chk("flag cleared", 8'(o_event_flags[5]), 8'h00);
		$display("test events done");
		@(negedge i_ref_clk);
		i_ce = 1'b0;
		cmd({OP_STALL, 4'h2});
		chk("frozen", 8'(o_halted[2]), 8'h00);
		i_ce = 1'b1;
		cmd({OP_STALL, 4'h2});
		chk("thawed", 8'(o_halted[2]), 8'h01);
		$display("test enable done");
		summarize();
	end
endmodule
